/* logic/meter_cfg_defines.svh */
`ifndef METER_CFG_DEFINES_SVH
`define METER_CFG_DEFINES_SVH

// Register offsets.
`define OFS_METER_PROC      6'h00
`define OFS_PHASE_DELAY     6'h05
`define OFS_SERIAL_CTRL     6'h07
`define OFS_PULSE_WIDTH     6'h08

// Reset values.
`define RST_METER_PROC      24'h000200
`define RST_PHASE_DELAY     24'h000000
`define RST_SERIAL_CTRL     24'h02004D
`define RST_PULSE_WIDTH     24'h000001

// Writable bit masks; reserved bits keep their reset value.
`define MSK_METER_PROC      24'hFE5FFF
`define MSK_PHASE_DELAY     24'hF3FFFF
`define MSK_SERIAL_CTRL     24'h06FFFF
`define MSK_PULSE_WIDTH     24'h0FFFFF

// Field positions in the processing configuration.
`define POS_FIXED_VREF      23
`define POS_POSITIVE_ONLY   22
`define POS_CHANNEL_CHOICE  21
`define POS_CHANNEL_HOLD    20
`define POS_MAG_SOURCE      19
`define POS_METER_MODE      17
`define POS_APPARENT        14
`define POS_ZX_LOWPASS      12
`define POS_AVG_BASIS       11
`define POS_CSUM_DISABLE    10
`define POS_AUTO_FREQ       9
`define POS_I2_FILTER       7
`define POS_V2_FILTER       5
`define POS_I1_FILTER       3
`define POS_V1_FILTER       1
`define POS_IIR_BYPASS      0

// Field positions in the other registers.
`define POS_COARSE2         22
`define POS_COARSE1         20
`define POS_FINE2           9
`define POS_FINE1           0
`define POS_PULLUP_DISABLE  18
`define POS_SER_CSUM_DIS    17
`define POS_BAUD            0
`define POS_PULSE_RANGE     16
`define POS_PULSE_DUR       0

// Timing and scaling constants.
`define BAUD_SCALE          524288
`define PULSE_BASE_US       250
`define PULSE_DIV           64000
`define PULSE_RANGE_MAX     4'h9

`endif

/* logic/meter_cfg_pkg.sv */
package meter_cfg_pkg;
   typedef enum logic [1:0] {
      MODE_ONE_CHANNEL = 2'h0,
      MODE_MEAN        = 2'h1,
      MODE_RSVD2       = 2'h2,
      MODE_RSVD3       = 2'h3
   } meter_mode_t;
   typedef enum logic [1:0] {
      FILT_NONE = 2'h0,
      FILT_HPF  = 2'h1,
      FILT_PMF  = 2'h2,
      FILT_INT  = 2'h3
   } filter_sel_t;
   typedef enum logic [1:0] {
      DLY_NONE = 2'h0,
      DLY_I1   = 2'h1,
      DLY_V1   = 2'h2,
      DLY_V2   = 2'h3
   } coarse_delay_t;
endpackage

/* logic/cfg_word_reg.sv */
`timescale 1ns/1ps
`default_nettype none
// One 24-bit configuration word; reserved bits hold their reset value.
module cfg_word_reg
   import meter_cfg_pkg::*;
#(
   parameter logic [23:0] RESET_VALUE = 24'h000000,
   parameter logic [23:0] WRITE_MASK  = 24'hFFFFFF
)
(
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   input  wire logic        i_write,
   input  wire logic [23:0] i_data,
   output var  logic [23:0] o_value
);
   // Masked update keeps reserved positions at their default.
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
         o_value <= RESET_VALUE;
      else if (i_write)
         o_value <= (i_data & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
   end
endmodule
`default_nettype wire

/* logic/pulse_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "meter_cfg_defines.svh"
// Energy pulse width and serial bit timing derived from the fields.
module pulse_timer
   import meter_cfg_pkg::*;
#(
   parameter int CLOCK_HZ = 50000000
)
(
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   input  wire logic [15:0] i_width,
   input  wire logic [15:0] i_baud,
   output var  logic [31:0] o_pulse_cycles,
   output var  logic [31:0] o_bit_cycles
);
   localparam longint BASE_CYC = (longint'(`PULSE_BASE_US) * CLOCK_HZ)
                                 / 1000000;
   logic [63:0] next_pulse;
   logic [63:0] next_bit;

   // Below 1 MHz the base pulse count loses too much resolution.
   if (CLOCK_HZ < 1000000)
   begin : g_bad_clock
      $error("pulse_timer: clock too slow");
   end

   // Pulse lasts base time plus width/64000 seconds.
   always_comb
   begin
      next_pulse = 64'(BASE_CYC) +
         (64'(i_width) * 64'(CLOCK_HZ)) / 64'(`PULSE_DIV);
      next_bit = (i_baud == 16'h0000) ? 64'h0 :
         64'(`BAUD_SCALE) / 64'(i_baud);
   end

   // Registered so the outputs never carry a long divider path glitch.
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_pulse_cycles <= 32'h0;
         o_bit_cycles   <= 32'h0;
      end
      else
      begin
         o_pulse_cycles <= next_pulse[31:0];
         o_bit_cycles   <= next_bit[31:0];
      end
   end
endmodule
`default_nettype wire

/* logic/meter_config_registers.sv */
`timescale 1ns/1ps
`default_nettype none
`include "meter_cfg_defines.svh"
module meter_config_registers
   import meter_cfg_pkg::*;
#(
   parameter int CLOCK_HZ = 50000000
)
(
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   input  wire logic [5:0]  i_addr,
   input  wire logic [23:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [23:0] o_rdata,
   output logic             o_fixed_voltage_ref_sel,
   output logic             o_positive_only,
   output logic             o_total_from_ch2,
   output logic             o_auto_select,
   output logic             o_magnitude_source_sel,
   output logic             o_total_mean,
   output logic             o_mode_reserved,
   output logic             o_apparent_method_sel,
   output logic             o_zero_cross_lowpass_en,
   output logic             o_averaging_basis_sel,
   output logic             o_critical_checksum_en,
   output logic             o_auto_line_freq_tracking,
   output logic [1:0]       o_current1_filter_sel,
   output logic [1:0]       o_current2_filter_sel,
   output logic [1:0]       o_voltage1_filter_sel,
   output logic [1:0]       o_voltage2_filter_sel,
   output logic             o_voltage_filter_reserved,
   output logic             o_recursive_filter_en,
   output logic [1:0]       o_current_delay1,
   output logic [1:0]       o_voltage_delay1,
   output logic [1:0]       o_current_delay2,
   output logic [1:0]       o_voltage_delay2,
   output logic [8:0]       o_fine_delay_pair1,
   output logic [8:0]       o_fine_delay_pair2,
   output logic             o_receive_pullup_en,
   output logic             o_serial_checksum_en,
   output logic [31:0]      o_bit_cycles,
   output logic [31:0]      o_pulse_cycles,
   output logic [3:0]       o_pulse_range_shift,
   output logic             o_pulse_range_reserved
);

   ////////////////////////////////////////////////////////////////////////
   // Reset synchroniser.
   logic rst_meta;
   logic rst_sync_b;

   // Release is synchronised so every flop leaves reset on the same edge.
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         rst_meta   <= 1'b0;
         rst_sync_b <= 1'b0;
      end
      else
      begin
         rst_meta   <= 1'b1;
         rst_sync_b <= rst_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register storage.
   logic [23:0] meter_processing_config;
   logic [23:0] phase_delay_trim;
   logic [23:0] serial_port_control;
   logic [23:0] energy_pulse_width_range;
   logic        wr_proc;
   logic        wr_phase;
   logic        wr_serial;
   logic        wr_pulse;

   // Address decode of the write strobe.
   assign wr_proc   = i_wr && (i_addr == `OFS_METER_PROC);
   assign wr_phase  = i_wr && (i_addr == `OFS_PHASE_DELAY);
   assign wr_serial = i_wr && (i_addr == `OFS_SERIAL_CTRL);
   assign wr_pulse  = i_wr && (i_addr == `OFS_PULSE_WIDTH);

   cfg_word_reg #(
      .RESET_VALUE (`RST_METER_PROC),
      .WRITE_MASK  (`MSK_METER_PROC)
   ) u_proc (
      .i_clock (i_clock),
      .i_rst_b (rst_sync_b),
      .i_write (wr_proc),
      .i_data  (i_wdata),
      .o_value (meter_processing_config)
   );

   cfg_word_reg #(
      .RESET_VALUE (`RST_PHASE_DELAY),
      .WRITE_MASK  (`MSK_PHASE_DELAY)
   ) u_phase (
      .i_clock (i_clock),
      .i_rst_b (rst_sync_b),
      .i_write (wr_phase),
      .i_data  (i_wdata),
      .o_value (phase_delay_trim)
   );

   cfg_word_reg #(
      .RESET_VALUE (`RST_SERIAL_CTRL),
      .WRITE_MASK  (`MSK_SERIAL_CTRL)
   ) u_serial (
      .i_clock (i_clock),
      .i_rst_b (rst_sync_b),
      .i_write (wr_serial),
      .i_data  (i_wdata),
      .o_value (serial_port_control)
   );

   cfg_word_reg #(
      .RESET_VALUE (`RST_PULSE_WIDTH),
      .WRITE_MASK  (`MSK_PULSE_WIDTH)
   ) u_pulse (
      .i_clock (i_clock),
      .i_rst_b (rst_sync_b),
      .i_write (wr_pulse),
      .i_data  (i_wdata),
      .o_value (energy_pulse_width_range)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read port: data stand in the cycle after the strobe only.
   logic [23:0] next_rdata;

   always_comb
   begin
      next_rdata = 24'h000000;
      if (i_rd)
      begin
         unique case (i_addr)
            `OFS_METER_PROC:  next_rdata = meter_processing_config;
            `OFS_PHASE_DELAY: next_rdata = phase_delay_trim;
            `OFS_SERIAL_CTRL: next_rdata = serial_port_control;
            `OFS_PULSE_WIDTH: next_rdata = energy_pulse_width_range;
            default:          next_rdata = 24'h000000;
         endcase
      end
   end

   // Unmapped reads answer zero; idle cycles also show zero.
   always_ff @(posedge i_clock or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
         o_rdata <= 24'h000000;
      else
         o_rdata <= next_rdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // Decoded processing controls.
   logic        chan_hold;
   meter_mode_t mode;
   assign chan_hold = meter_processing_config[`POS_CHANNEL_HOLD];
   assign mode = meter_mode_t'(meter_processing_config[`POS_METER_MODE+:2]);

   // Total-power source selection and per-bit options, all registered.
   always_ff @(posedge i_clock or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         o_fixed_voltage_ref_sel   <= 1'b0;
         o_positive_only           <= 1'b0;
         o_total_from_ch2          <= 1'b0;
         o_auto_select             <= 1'b0;
         o_magnitude_source_sel    <= 1'b0;
         o_total_mean              <= 1'b0;
         o_mode_reserved           <= 1'b0;
         o_apparent_method_sel     <= 1'b0;
         o_zero_cross_lowpass_en   <= 1'b0;
         o_averaging_basis_sel     <= 1'b0;
         o_critical_checksum_en    <= 1'b0;
         o_auto_line_freq_tracking <= 1'b0;
         o_recursive_filter_en     <= 1'b0;
      end
      else
      begin
         o_fixed_voltage_ref_sel <= meter_processing_config[`POS_FIXED_VREF];
         o_positive_only <= meter_processing_config[`POS_POSITIVE_ONLY];
         o_total_mean    <= (mode == MODE_MEAN);
         o_mode_reserved <= (mode == MODE_RSVD2) || (mode == MODE_RSVD3);
         o_total_from_ch2 <= (mode == MODE_ONE_CHANNEL) && chan_hold &&
            meter_processing_config[`POS_CHANNEL_CHOICE];
         o_auto_select <= (mode == MODE_ONE_CHANNEL) && !chan_hold;
         o_magnitude_source_sel <= meter_processing_config[`POS_MAG_SOURCE];
         o_apparent_method_sel <= meter_processing_config[`POS_APPARENT];
         o_zero_cross_lowpass_en <= meter_processing_config[`POS_ZX_LOWPASS];
         o_averaging_basis_sel <= meter_processing_config[`POS_AVG_BASIS];
         o_critical_checksum_en <=
            !meter_processing_config[`POS_CSUM_DISABLE];
         o_auto_line_freq_tracking <=
            meter_processing_config[`POS_AUTO_FREQ];
         o_recursive_filter_en <= !meter_processing_config[`POS_IIR_BYPASS];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Input filter selects and coarse delay split.
   filter_sel_t   v1_flt;
   filter_sel_t   v2_flt;
   coarse_delay_t cd1;
   coarse_delay_t cd2;
   assign v1_flt = filter_sel_t'(meter_processing_config[`POS_V1_FILTER+:2]);
   assign v2_flt = filter_sel_t'(meter_processing_config[`POS_V2_FILTER+:2]);
   assign cd1 = coarse_delay_t'(phase_delay_trim[`POS_COARSE1+:2]);
   assign cd2 = coarse_delay_t'(phase_delay_trim[`POS_COARSE2+:2]);

   // Delay in sample periods for one path of a pair.
   function automatic logic [1:0] current_periods(input coarse_delay_t c);
      current_periods = (c == DLY_I1) ? 2'h1 : 2'h0;
   endfunction

   function automatic logic [1:0] voltage_periods(input coarse_delay_t c);
      logic [1:0] p;
      p = 2'h0;
      unique case (c)
         DLY_NONE: p = 2'h0;
         DLY_I1:   p = 2'h0;
         DLY_V1:   p = 2'h1;
         DLY_V2:   p = 2'h2;
      endcase
      voltage_periods = p;
   endfunction

   // Filters and phase trims handed to the sample path.
   always_ff @(posedge i_clock or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         o_current1_filter_sel     <= 2'h0;
         o_current2_filter_sel     <= 2'h0;
         o_voltage1_filter_sel     <= 2'h0;
         o_voltage2_filter_sel     <= 2'h0;
         o_voltage_filter_reserved <= 1'b0;
         o_current_delay1          <= 2'h0;
         o_voltage_delay1          <= 2'h0;
         o_current_delay2          <= 2'h0;
         o_voltage_delay2          <= 2'h0;
         o_fine_delay_pair1        <= 9'h000;
         o_fine_delay_pair2        <= 9'h000;
      end
      else
      begin
         o_current1_filter_sel <= meter_processing_config[`POS_I1_FILTER+:2];
         o_current2_filter_sel <= meter_processing_config[`POS_I2_FILTER+:2];
         // Voltage filter, reserved code runs unfiltered
         o_voltage1_filter_sel <= (v1_flt == FILT_INT) ? 2'h0 : v1_flt;
         o_voltage2_filter_sel <= (v2_flt == FILT_INT) ? 2'h0 : v2_flt;
         o_voltage_filter_reserved <= (v1_flt == FILT_INT) ||
                                      (v2_flt == FILT_INT);
         o_current_delay1 <= current_periods(cd1);
         o_voltage_delay1 <= voltage_periods(cd1);
         o_current_delay2 <= current_periods(cd2);
         o_voltage_delay2 <= voltage_periods(cd2);
         o_fine_delay_pair1 <= phase_delay_trim[`POS_FINE1+:9];
         o_fine_delay_pair2 <= phase_delay_trim[`POS_FINE2+:9];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial port and energy pulse controls.
   logic [3:0] range_code;
   logic [31:0] pulse_cycles;
   logic [31:0] bit_cycles;
   assign range_code = energy_pulse_width_range[`POS_PULSE_RANGE+:4];

   pulse_timer #(
      .CLOCK_HZ (CLOCK_HZ)
   ) u_timer (
      .i_clock        (i_clock),
      .i_rst_b        (rst_sync_b),
      .i_width        (energy_pulse_width_range[`POS_PULSE_DUR+:16]),
      .i_baud         (serial_port_control[`POS_BAUD+:16]),
      .o_pulse_cycles (pulse_cycles),
      .o_bit_cycles   (bit_cycles)
   );

   // Extra stage keeps every top output on a flop of this module.
   always_ff @(posedge i_clock or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         o_receive_pullup_en    <= 1'b1;
         o_serial_checksum_en   <= 1'b0;
         o_bit_cycles           <= 32'h0;
         o_pulse_cycles         <= 32'h0;
         o_pulse_range_shift    <= 4'h0;
         o_pulse_range_reserved <= 1'b0;
      end
      else
      begin
         o_receive_pullup_en <= !serial_port_control[`POS_PULLUP_DISABLE];
         o_serial_checksum_en <= !serial_port_control[`POS_SER_CSUM_DIS];
         o_bit_cycles   <= bit_cycles;
         o_pulse_cycles <= pulse_cycles;
         o_pulse_range_shift <= (range_code > `PULSE_RANGE_MAX) ?
            `PULSE_RANGE_MAX : range_code;
         o_pulse_range_reserved <= (range_code > `PULSE_RANGE_MAX);
      end
   end

endmodule
`default_nettype wire

/* verif/meter_config_registers_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "meter_cfg_defines.svh"
// Watches the register port and the decoded configuration fields.
module meter_cfg_checker
(
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   input  wire logic [5:0]  i_addr,
   input  wire logic [23:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic [23:0] o_rdata,
   input  wire logic        o_fixed_voltage_ref_sel,
   input  wire logic        o_total_from_ch2,
   input  wire logic        o_auto_select,
   input  wire logic        o_total_mean,
   input  wire logic        o_mode_reserved,
   input  wire logic        o_critical_checksum_en,
   input  wire logic [1:0]  o_voltage1_filter_sel,
   input  wire logic        o_recursive_filter_en,
   input  wire logic [1:0]  o_voltage_delay2,
   input  wire logic [8:0]  o_fine_delay_pair2,
   input  wire logic        o_receive_pullup_en,
   input  wire logic        o_pulse_range_reserved
);
   /////////////////////////////////////////////////////////////
   // Write strokes per register; a lone write gives the decode time.
   wire logic wp = i_wr && (i_addr == `OFS_METER_PROC);
   wire logic wc = i_wr && (i_addr == `OFS_PHASE_DELAY);
   wire logic ws = i_wr && (i_addr == `OFS_SERIAL_CTRL);
   wire logic wl = i_wr && (i_addr == `OFS_PULSE_WIDTH);
   wire logic mapped = i_addr inside {`OFS_METER_PROC, `OFS_PHASE_DELAY,
                                      `OFS_SERIAL_CTRL, `OFS_PULSE_WIDTH};

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);

   /////////////////////////////////////////////////////////////
   AST_FIXED_VREF: assert property (wp ##1 !wp |-> ##1
      o_fixed_voltage_ref_sel == $past(i_wdata[23], 2)) else $error("vref");
   // The magnitude source bit plays no part in the held channel choice.
   AST_CH2_TOTAL: assert property (wp ##1 !wp |-> ##1
      o_total_from_ch2 == ($past(i_wdata[21:20], 2) == 2'h3 &&
      $past(i_wdata[18:17], 2) == 2'h0)) else $error("ch2 total");
   AST_MODE_EXCL: assert property ($onehot0({o_total_mean,
      o_mode_reserved, o_auto_select, o_total_from_ch2})) else $error("mode");
   AST_CSUM_EN: assert property (wp ##1 !wp |-> ##1
      o_critical_checksum_en == !$past(i_wdata[10], 2)) else $error("csum");
   AST_VFILT: assert property (wp ##1 !wp |-> ##1
      o_voltage1_filter_sel == (($past(i_wdata[2:1], 2) == 2'h3) ? 2'h0 :
      $past(i_wdata[2:1], 2))) else $error("vfilter");
   AST_IIR: assert property (wp ##1 !wp |-> ##1
      o_recursive_filter_en == !$past(i_wdata[0], 2)) else $error("iir");
   AST_COARSE: assert property (wc ##1 !wc |-> ##1
      o_voltage_delay2 == (($past(i_wdata[23:22], 2) == 2'h3) ? 2'h2 :
      ($past(i_wdata[23:22], 2) == 2'h2) ? 2'h1 : 2'h0)) else $error("coarse");
   AST_FINE: assert property (wc ##1 !wc |-> ##1
      o_fine_delay_pair2 == $past(i_wdata[17:9], 2)) else $error("fine");
   AST_PULLUP: assert property (ws ##1 !ws |-> ##1
      o_receive_pullup_en == !$past(i_wdata[18], 2)) else $error("pullup");
   AST_RANGE: assert property (wl ##1 !wl |-> ##1
      o_pulse_range_reserved == ($past(i_wdata[19:16], 2) > 4'h9))
      else $error("range");
   AST_READBACK: assert property (wp ##1
      (i_rd && i_addr == `OFS_METER_PROC) |=> o_rdata ==
      (($past(i_wdata, 2) & `MSK_METER_PROC) |
      (`RST_METER_PROC & ~`MSK_METER_PROC))) else $error("readback");
   AST_UNMAPPED: assert property (i_rd && !mapped |=>
      o_rdata == 24'h0) else $error("unmapped read");
endmodule

bind meter_config_registers meter_cfg_checker i_chk (.i_clock, .i_rst_b,
   .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_fixed_voltage_ref_sel,
   .o_total_from_ch2, .o_auto_select, .o_total_mean, .o_mode_reserved,
   .o_critical_checksum_en, .o_voltage1_filter_sel, .o_recursive_filter_en,
   .o_voltage_delay2, .o_fine_delay_pair2, .o_receive_pullup_en,
   .o_pulse_range_reserved);
`default_nettype wire

/* verif/test_meter_config_registers.sv */
`timescale 1ns/1ps
`default_nettype none
`include "meter_cfg_defines.svh"
// Self-checking bench for the configuration register bank.
module test_meter_config_registers
   import meter_cfg_pkg::*;
;
   localparam int CLK_HZ = 50000000;
   localparam logic [5:0] OFS [4] = '{`OFS_METER_PROC, `OFS_PHASE_DELAY,
                                      `OFS_SERIAL_CTRL, `OFS_PULSE_WIDTH};
   localparam logic [23:0] RST [4] = '{`RST_METER_PROC, `RST_PHASE_DELAY,
                                       `RST_SERIAL_CTRL, `RST_PULSE_WIDTH};
   localparam logic [23:0] MSK [4] = '{`MSK_METER_PROC, `MSK_PHASE_DELAY,
                                       `MSK_SERIAL_CTRL, `MSK_PULSE_WIDTH};
   logic        i_clock, i_rst_b, i_wr, i_rd;
   logic [5:0]  i_addr;
   logic [23:0] i_wdata, o_rdata;
   logic        o_fixed_voltage_ref_sel, o_positive_only, o_total_from_ch2;
   logic        o_auto_select, o_magnitude_source_sel, o_total_mean;
   logic        o_mode_reserved, o_apparent_method_sel;
   logic        o_zero_cross_lowpass_en, o_averaging_basis_sel;
   logic        o_critical_checksum_en, o_auto_line_freq_tracking;
   logic        o_voltage_filter_reserved, o_recursive_filter_en;
   logic        o_receive_pullup_en, o_serial_checksum_en;
   logic        o_pulse_range_reserved;
   logic [1:0]  o_current1_filter_sel, o_current2_filter_sel;
   logic [1:0]  o_voltage1_filter_sel, o_voltage2_filter_sel;
   logic [1:0]  o_current_delay1, o_voltage_delay1;
   logic [1:0]  o_current_delay2, o_voltage_delay2;
   logic [8:0]  o_fine_delay_pair1, o_fine_delay_pair2;
   logic [31:0] o_bit_cycles, o_pulse_cycles;
   logic [3:0]  o_pulse_range_shift;
   int          fails, checked;

   meter_config_registers #(.CLOCK_HZ(CLK_HZ)) i_dut (.i_clock, .i_rst_b,
      .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_fixed_voltage_ref_sel,
      .o_positive_only, .o_total_from_ch2, .o_auto_select,
      .o_magnitude_source_sel, .o_total_mean, .o_mode_reserved,
      .o_apparent_method_sel, .o_zero_cross_lowpass_en,
      .o_averaging_basis_sel, .o_critical_checksum_en,
      .o_auto_line_freq_tracking, .o_current1_filter_sel,
      .o_current2_filter_sel, .o_voltage1_filter_sel, .o_voltage2_filter_sel,
      .o_voltage_filter_reserved, .o_recursive_filter_en, .o_current_delay1,
      .o_voltage_delay1, .o_current_delay2, .o_voltage_delay2,
      .o_fine_delay_pair1, .o_fine_delay_pair2, .o_receive_pullup_en,
      .o_serial_checksum_en, .o_bit_cycles, .o_pulse_cycles,
      .o_pulse_range_shift, .o_pulse_range_reserved);

   // Free-running 50 MHz clock.
   initial
   begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end

   ////////////////////////////////////////////////////////////
   // Comparison, verdict and bus cycles shared by all scenarios.
   task check(input string name, input logic [31:0] seen,
              input logic [31:0] exp);
   begin
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   end
   endtask

   task stop_test;
   begin
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask

   // One bus cycle; each call assigns every strobe once per edge.
   task access(input logic wr, input logic rd, input logic [5:0] a,
               input logic [23:0] d);
   begin
      @(posedge i_clock);
      i_wr <= wr;
      i_rd <= rd;
      i_addr <= a;
      i_wdata <= d;
   end
   endtask

   task get(input logic [5:0] a, output logic [23:0] r);
   begin
      access(1'b0, 1'b1, a, 24'h0);
      access(1'b0, 1'b0, 6'h00, 24'h0);
      #1 r = o_rdata;
   end
   endtask

   function automatic logic [1:0] cd(input logic [1:0] c);
      return (c == 2'h1) ? 2'h1 : 2'h0;
   endfunction

   function automatic logic [1:0] vd(input logic [1:0] c);
      return (c == 2'h3) ? 2'h2 : (c == 2'h2) ? 2'h1 : 2'h0;
   endfunction

   // Compares every decoded output of register k against word w.
   task chk(input int k, input logic [23:0] w);
      logic [1:0] v1, v2, m;
      logic [3:0] rc;
      longint     dur;
   begin
      v1 = (w[2:1] == 2'h3) ? 2'h0 : w[2:1];
      v2 = (w[6:5] == 2'h3) ? 2'h0 : w[6:5];
      m = w[18:17];
      rc = w[19:16];
      dur = longint'(`PULSE_BASE_US) * CLK_HZ / 1000000 +
            longint'(w[15:0]) * CLK_HZ / `PULSE_DIV;
      case (k)
      0:
      begin
         check("vref", o_fixed_voltage_ref_sel, w[23]);
         check("positive_only", o_positive_only, w[22]);
         check("mag_source", o_magnitude_source_sel, w[19]);
         check("apparent", o_apparent_method_sel, w[14]);
         check("zx_lowpass", o_zero_cross_lowpass_en, w[12]);
         check("avg_basis", o_averaging_basis_sel, w[11]);
         check("csum_en", o_critical_checksum_en, !w[10]);
         check("freq_track", o_auto_line_freq_tracking, w[9]);
         check("iir_en", o_recursive_filter_en, !w[0]);
         check("mode", {o_auto_select, o_total_from_ch2, o_total_mean,
            o_mode_reserved}, {m == 2'h0 && !w[20], m == 2'h0 && w[20] &&
            w[21], m == 2'h1, m[1]});
         check("filters", {o_current2_filter_sel, o_voltage2_filter_sel,
            o_current1_filter_sel, o_voltage1_filter_sel,
            o_voltage_filter_reserved}, {w[8:7], v2, w[4:3], v1,
            w[6:5] == 2'h3 || w[2:1] == 2'h3});
      end
      1: check("delays", {o_current_delay2, o_voltage_delay2,
            o_current_delay1, o_voltage_delay1, o_fine_delay_pair2,
            o_fine_delay_pair1}, {cd(w[23:22]), vd(w[23:22]), cd(w[21:20]),
            vd(w[21:20]), w[17:0]});
      2:
      begin
         check("serial_bits", {o_receive_pullup_en, o_serial_checksum_en},
            {~w[18], ~w[17]});
         check("bit_cycles", o_bit_cycles, (w[15:0] == 16'h0) ? 32'h0 :
            `BAUD_SCALE / w[15:0]);
      end
      default:
      begin
         check("range", {o_pulse_range_reserved, o_pulse_range_shift},
            {rc > 4'h9, (rc > 4'h9) ? 4'h9 : rc});
         check("pulse_cycles", o_pulse_cycles, dur[31:0]);
      end
      endcase
   end
   endtask

   // Write, read straight back, let the timing stages settle, then judge.
   task put(input int k, input logic [23:0] w);
      logic [23:0] r;
   begin
      access(1'b1, 1'b0, OFS[k], w);
      get(OFS[k], r);
      check("readback", r, (w & MSK[k]) | (RST[k] & ~MSK[k]));
      repeat (5) access(1'b0, 1'b0, 6'h00, 24'h0);
      #1;
      chk(k, w);
   end
   endtask

   ////////////////////////////////////////////////////////////
   // Scenarios.
   task t_reset_state;
      logic [23:0] r;
   begin
      access(1'b1, 1'b0, 6'h3F, 24'hFFFFFF);
      for (int k = 0; k < 4; k++)
      begin
         get(OFS[k], r);
         check("reset_value", r, RST[k]);
         chk(k, RST[k]);
      end
      get(6'h01, r);
      check("unmapped", r, 24'h0);
   end
   endtask

   task t_proc;
      logic [23:0] tbl [9] = '{24'h0, 24'hFFFFFF, 24'h300000, 24'h100000,
                               24'h060000, 24'h0AA, 24'h154, 24'h1FE,
                               24'h380000};
   begin
      for (int i = 0; i < 24; i++)
         put(0, 24'h1 << i);
      foreach (tbl[i])
         put(0, tbl[i]);
   end
   endtask

   task t_phase;
   begin
      for (int k = 0; k < 4; k++)
         put(1, {k[1:0], ~k[1:0], 2'h3, k[0] ? 18'h3FE00 : 18'h001FF});
   end
   endtask

   task t_serial;
      logic [23:0] tbl [6] = '{24'hFFFFFF, 24'h000001, 24'h040000,
                               24'h020000, 24'h000000, 24'h00004D};
   begin
      foreach (tbl[i])
         put(2, tbl[i]);
   end
   endtask

   task t_pulse;
   begin
      for (int k = 0; k < 16; k++)
         put(3, {4'hF, k[3:0], (16'h1111 * k[15:0]) | 16'h0001});
   end
   endtask

   task t_midrun_reset;
   begin
      @(posedge i_clock);
      i_rst_b <= 1'b0;
      repeat (5) @(posedge i_clock);
      i_rst_b <= 1'b1;
      repeat (4) access(1'b0, 1'b0, 6'h00, 24'h0);
      t_reset_state;
   end
   endtask

   ////////////////////////////////////////////////////////////
   // Main sequence and a watchdog that cuts a hang short.
   initial
   begin
      fails = 0;
      checked = 0;
      i_rst_b = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 6'h00;
      i_wdata = 24'h0;
      repeat (5) @(posedge i_clock);
      i_rst_b <= 1'b1;
      repeat (4) access(1'b0, 1'b0, 6'h00, 24'h0);
      t_reset_state;
      t_proc;
      t_phase;
      t_serial;
      t_pulse;
      t_midrun_reset;
      stop_test;
   end

   initial
   begin
      repeat (20000) @(posedge i_clock);
      fails++;
      stop_test;
   end
endmodule
`default_nettype wire
